/* File: fqs_pkg.sv */
`default_nettype none

package fqs_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned NUM_Q     = 14;
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned QNUM_W    = 4;
  localparam int unsigned NUM_CREG  = 7;

  // ==========================================================
  // field positions inside a count register
  localparam int unsigned LO_LSB    = 0;
  localparam int unsigned HI_LSB    = 8;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_CNT_Q0_Q1   = 4'h0;
  localparam logic [3:0] OFS_CNT_Q2_Q3   = 4'h1;
  localparam logic [3:0] OFS_CNT_Q4_Q5   = 4'h2;
  localparam logic [3:0] OFS_CNT_Q6_Q7   = 4'h3;
  localparam logic [3:0] OFS_CNT_Q8_Q9   = 4'h4;
  localparam logic [3:0] OFS_CNT_Q10_Q11 = 4'h5;
  localparam logic [3:0] OFS_CNT_Q12_Q13 = 4'h6;
  localparam logic [3:0] OFS_INT_STATUS  = 4'h8;
  localparam logic [3:0] OFS_INT_MASK    = 4'h9;
  localparam logic [3:0] OFS_NONZERO_MAP = 4'ha;

  // ==========================================================
  // interrupt status bits
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_STARVE   = 0;
  localparam int unsigned IRQ_OVERFLOW = 1;
  localparam int unsigned IRQ_FOREIGN  = 2;

  // ==========================================================
  // reset values and counter saturation limit
  localparam logic [7:0]  CNT_RST    = 8'h00;
  localparam logic [7:0]  CNT_MAX    = 8'hff;
  localparam logic [2:0]  STATUS_RST = 3'h0;
  localparam logic [2:0]  MASK_RST   = 3'h0;
  localparam logic [15:0] RDATA_RST  = 16'h0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic                valid;
    logic [QNUM_W-1:0]   qnum;
    logic                empty;
  } fqs_pop_s;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [REG_W-1:0]    wdata;
  } fqs_bus_s;

endpackage : fqs_pkg

`default_nettype wire

/* File: fqs_tally.sv */
`timescale 1ns/1ps
`default_nettype none

module fqs_tally #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // control
  input  wire logic         inc,
  input  wire logic         clr,
  // count
  output logic [W-1:0]      cnt
);

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] TOP = {W{1'b1}};

  logic [W-1:0] next_cnt;

  // ==========================================================
  // next value
  always_comb begin
    next_cnt = cnt;
    if (clr) begin
      next_cnt = inc ? ONE : '0;    // RULE2 RULE7
    end else if (inc && cnt != TOP) begin
      next_cnt = cnt + ONE;         // RULE1 RULE3 RULE7
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule : fqs_tally

`default_nettype wire

/* File: fqs_top.sv */
// Operation
// RULE1 - an empty-queue pop adds one to that queue's counter
// RULE2 - reading a count register returns counts, then zeroes both fields
// RULE3 - each counter is an 8-bit unsigned value, 0 to ff
// RULE4 - register n holds queue 2n low byte, queue 2n+1 high byte
// RULE5 - software uses whole 16-bit accesses only, no byte access
// RULE6 - only receive free queues 0 to 13 are counted
// RULE7 - counter holds at ff; event during clearing read leaves one
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module fqs_top (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // pop path from receive channels
  input  wire fqs_pkg::fqs_pop_s pop,
  // register port
  input  wire fqs_pkg::fqs_bus_s bus,
  output logic [15:0]           rdata,
  // interrupt
  output logic                  irq
);
  import fqs_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic is_cnt_reg(input logic [ADDR_W-1:0] a);
    return a <= OFS_CNT_Q12_Q13;
  endfunction : is_cnt_reg

  function automatic logic [ADDR_W-1:0] reg_of_queue(input int unsigned q);
    return ADDR_W'(q >> 1);
  endfunction : reg_of_queue

  // ==========================================================
  // declarations
  logic [CNT_W-1:0] tally [NUM_Q];
  logic [NUM_Q-1:0] inc_vec;
  logic [NUM_Q-1:0] clr_vec;
  logic [NUM_Q-1:0] full_vec;
  logic [NUM_Q-1:0] nonzero;
  logic             starve_ev;
  logic             counted_q;
  logic             overflow_ev;
  logic             foreign_ev;
  logic             cnt_read;
  logic [IRQ_W-1:0] status;
  logic [IRQ_W-1:0] mask;
  logic [IRQ_W-1:0] set_vec;
  logic [IRQ_W-1:0] w1c_vec;
  logic [IRQ_W-1:0] next_status;
  logic [REG_W-1:0] next_rdata;

  // ==========================================================
  // pop decode
  assign starve_ev  = pop.valid && pop.empty;
  assign counted_q  = 32'(pop.qnum) < NUM_Q;                        // RULE6
  assign foreign_ev = starve_ev && !counted_q;
  assign cnt_read   = bus.rd && is_cnt_reg(bus.addr);

  always_comb begin
    for (int unsigned i = 0; i < NUM_Q; i++) begin
      inc_vec[i]  = starve_ev && counted_q && 32'(pop.qnum) == i;   // RULE1 RULE6
      clr_vec[i]  = cnt_read && bus.addr == reg_of_queue(i);        // RULE2
      full_vec[i] = tally[i] == CNT_MAX;
      nonzero[i]  = tally[i] != CNT_RST;
    end
  end

  // lost event: counter already at top and not being cleared
  assign overflow_ev = |(inc_vec & full_vec & ~clr_vec);            // RULE7

  // ==========================================================
  // counters
  for (genvar g = 0; g < NUM_Q; g++) begin : g_tally
    fqs_tally #(
      .W   (CNT_W)
    ) u_tally (
      .clk    (clk),
      .arst_n (arst_n),
      .inc    (inc_vec[g]),
      .clr    (clr_vec[g]),
      .cnt    (tally[g])
    );

    tally_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE1
      !inc_vec[g] && !clr_vec[g]
      |=> $stable(tally[g]))
      else $error("counter moved without its own event or read");

    tally_clear_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE2
      clr_vec[g] && !inc_vec[g]
      |=> tally[g] == CNT_RST)
      else $error("counter not zeroed by its register read");

    tally_sat_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE7
      inc_vec[g] && !clr_vec[g] && tally[g] == CNT_MAX
      |=> tally[g] == CNT_MAX)
      else $error("counter left ff on an event");
  end

  // ==========================================================
  // read data: captured before the clear takes effect
  always_comb begin
    next_rdata = RDATA_RST;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_CNT_Q0_Q1, OFS_CNT_Q2_Q3, OFS_CNT_Q4_Q5, OFS_CNT_Q6_Q7,
        OFS_CNT_Q8_Q9, OFS_CNT_Q10_Q11, OFS_CNT_Q12_Q13: begin
          next_rdata[HI_LSB +: CNT_W] = tally[{bus.addr[2:0], 1'b1}];  // RULE4
          next_rdata[LO_LSB +: CNT_W] = tally[{bus.addr[2:0], 1'b0}];  // RULE4
        end
        OFS_INT_STATUS: begin
          next_rdata[IRQ_W-1:0] = status;
        end
        OFS_INT_MASK: begin
          next_rdata[IRQ_W-1:0] = mask;
        end
        OFS_NONZERO_MAP: begin
          next_rdata[NUM_Q-1:0] = nonzero;
        end
        default: begin
          next_rdata = RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= RDATA_RST;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // read port checks
  rdata_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !bus.rd
    |=> rdata == RDATA_RST)
    else $error("read data did not return to zero after its cycle");

  read_status_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus.rd && bus.addr == OFS_INT_STATUS
    |=> rdata == {{(REG_W-IRQ_W){1'b0}}, $past(status)})
    else $error("status read returned wrong value");

  read_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus.rd && bus.addr == OFS_INT_MASK
    |=> rdata == {{(REG_W-IRQ_W){1'b0}}, $past(mask)})
    else $error("mask read returned wrong value");

  read_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus.rd && bus.addr == OFS_NONZERO_MAP
    |=> rdata == {{(REG_W-NUM_Q){1'b0}}, $past(nonzero)})
    else $error("nonzero map read returned wrong value");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus.rd && bus.addr > OFS_NONZERO_MAP
    |=> rdata == RDATA_RST)
    else $error("unmapped read returned nonzero data");

  // ==========================================================
  // interrupt mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask <= MASK_RST;
    end else if (bus.wr && bus.addr == OFS_INT_MASK) begin
      mask <= bus.wdata[IRQ_W-1:0];
    end
  end

  mask_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus.wr && bus.addr == OFS_INT_MASK
    |=> mask == $past(bus.wdata[IRQ_W-1:0]))
    else $error("mask write did not land");

  // ==========================================================
  // interrupt status: write one to clear, a new event wins
  always_comb begin
    set_vec               = '0;
    set_vec[IRQ_STARVE]   = |inc_vec;
    set_vec[IRQ_OVERFLOW] = overflow_ev;
    set_vec[IRQ_FOREIGN]  = foreign_ev;
    w1c_vec               = '0;
    if (bus.wr && bus.addr == OFS_INT_STATUS) begin
      w1c_vec = bus.wdata[IRQ_W-1:0];
    end
    next_status = (status & ~w1c_vec) | set_vec;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  // ==========================================================
  // status checks
  starve_flag_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE1
    starve_ev && counted_q
    |=> status[IRQ_STARVE])
    else $error("counted starvation did not raise its flag");

  set_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
    set_vec != '0
    |=> (status & $past(set_vec)) == $past(set_vec))
    else $error("clearing write beat a new event");

  status_w1c_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus.wr && bus.addr == OFS_INT_STATUS && set_vec == '0
    |=> (status & $past(bus.wdata[IRQ_W-1:0])) == '0)
    else $error("write one did not clear status");

  status_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(bus.wr && bus.addr == OFS_INT_STATUS)
    |=> (status & $past(status)) == $past(status))
    else $error("status bit dropped without a clearing write");

  starve_cause_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE1
    $rose(status[IRQ_STARVE])
    |-> $past(starve_ev && counted_q))
    else $error("starvation flag rose with no counted event");

  overflow_cause_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE7
    $rose(status[IRQ_OVERFLOW])
    |-> $past(starve_ev && counted_q && tally[pop.qnum] == CNT_MAX))
    else $error("overflow flag rose with no event on a full counter");

  foreign_cause_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE6
    $rose(status[IRQ_FOREIGN])
    |-> $past(pop.valid && pop.empty && pop.qnum >= QNUM_W'(NUM_Q)))
    else $error("foreign queue flag rose with no such pop");

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else if (bus.wr && bus.addr == OFS_INT_MASK) begin
      irq <= |(next_status & bus.wdata[IRQ_W-1:0]);
    end else begin
      irq <= |(next_status & mask);
    end
  end

  irq_mask_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    bus.wr && bus.addr == OFS_INT_MASK
    |=> irq == |(status & $past(bus.wdata[IRQ_W-1:0])))
    else $error("interrupt did not follow a new mask at once");

  // ==========================================================
  // checks
  logic [NUM_Q*CNT_W-1:0] tally_flat;

  always_comb begin
    for (int unsigned i = 0; i < NUM_Q; i++) begin
      tally_flat[i*CNT_W +: CNT_W] = tally[i];
    end
  end

  count_up_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE1
    (starve_ev && counted_q && !cnt_read && tally[pop.qnum] != CNT_MAX)
    |=> tally[$past(pop.qnum)] == $past(tally[pop.qnum]) + 8'h01)
    else $error("empty pop did not add one to its counter");

  read_value_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE4
    cnt_read |=> rdata == $past({tally[{bus.addr[2:0], 1'b1}], tally[{bus.addr[2:0], 1'b0}]}))
    else $error("count register read returned wrong fields");

  read_clear_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE2
    (cnt_read && !starve_ev)
    |=> tally[{$past(bus.addr[2:0]), 1'b0}] == 8'h00 && tally[{$past(bus.addr[2:0]), 1'b1}] == 8'h00)
    else $error("count register not cleared by read");

  count_hold_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE3
    !(starve_ev && counted_q) && !cnt_read |=> $stable(tally_flat))
    else $error("counter changed with no event and no read");

  foreign_q_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE6
    (starve_ev && !counted_q && !cnt_read) |=> $stable(tally_flat) && status[IRQ_FOREIGN])
    else $error("pop outside counted queues touched a counter");

  sat_hold_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE7
    (inc_vec != '0 && tally[pop.qnum] == CNT_MAX && !cnt_read)
    |=> tally[$past(pop.qnum)] == 8'hff && status[IRQ_OVERFLOW])
    else $error("full counter wrapped");

  clear_race_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE7
    (|(inc_vec & clr_vec)) |=> tally[$past(pop.qnum)] == 8'h01)
    else $error("event during clearing read was lost");

  irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 irq == |(status & mask))
    else $error("interrupt does not follow masked status");

  count_write_a: assert property (@(posedge clk) disable iff (!arst_n)  // RULE2
    bus.wr && is_cnt_reg(bus.addr) && !starve_ev
    |=> $stable(tally_flat))
    else $error("write to a count register changed a counter");

endmodule : fqs_top

`default_nettype wire

/* File: fqs_pop_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fqs_pop_model (
  // clock
  input  wire logic             clk,
  // pop path toward the counters
  output var fqs_pkg::fqs_pop_s pop
);
  import fqs_pkg::*;

  initial pop = '{1'b0, 4'h0, 1'b0};

  // ==========================================================
  // one attempt per cycle; released fields are inverted so stale values never pass
  task automatic attempt(input logic [3:0] q, input logic e, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      pop <= '{1'b1, q, e};
    end
    @(posedge clk);
    pop <= '{1'b0, ~q, ~e};
  endtask : attempt

endmodule : fqs_pop_model

`default_nettype wire

/* File: free_queue_starvation_counters_test.sv */
`timescale 1ns/1ps
`default_nettype none

module free_queue_starvation_counters_test;
  import fqs_pkg::*;

  logic        clk;
  logic        arst_n;
  fqs_bus_s    bus;
  fqs_pop_s    pop;
  logic [15:0] rdata;
  logic        irq;
  int          errors;
  int          check_count;

  fqs_top uut (.clk(clk), .arst_n(arst_n), .pop(pop), .bus(bus), .rdata(rdata), .irq(irq));
  fqs_pop_model model (.clk(clk), .pop(pop));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // compare and bus tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '{1'b0, 1'b0, a, d};
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    bus <= '{1'b0, 1'b0, a, 16'h0000};
    #1;
    chk(rdata, exp);
  endtask : rd

  task automatic finish_test;
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // ==========================================================
  // watchdog
  initial begin
    #100000;
    errors++;
    finish_test();
  end

  // ==========================================================
  // tests
  initial begin
    arst_n = 1'b0;
    bus = '{1'b0, 1'b0, 4'h0, 16'h0000};
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
    wr(4'h9, 16'h0001);
    // queue q starves q+1 times; non-empty pops must not count
    for (int q = 0; q < 14; q++) model.attempt(q[3:0], 1'b1, q + 1);
    model.attempt(4'h5, 1'b0, 3);
    chk({15'h0000, irq}, 16'h0001);
    rd(4'ha, 16'h3fff);
    for (int n = 0; n < 7; n++) rd(n[3:0], {8'(2 * n + 2), 8'(2 * n + 1)});
    for (int n = 0; n < 7; n++) rd(n[3:0], 16'h0000);
    rd(4'h8, 16'h0001);
    wr(4'h8, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    // queues outside the receive range keep no count
    model.attempt(4'he, 1'b1, 1);
    model.attempt(4'hf, 1'b1, 1);
    rd(4'h8, 16'h0004);
    rd(4'ha, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(4'h9, 16'h0007);
    chk({15'h0000, irq}, 16'h0001);
    wr(4'h8, 16'h0007);
    chk({15'h0000, irq}, 16'h0000);
    // saturation at ff
    model.attempt(4'h0, 1'b1, 260);
    rd(4'h8, 16'h0003);
    rd(4'h0, 16'h00ff);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h0000);
    // starvation in the same cycle as the clearing read
    fork
      model.attempt(4'h2, 1'b1, 1);
      rd(4'h1, 16'h0000);
    join
    rd(4'h1, 16'h0001);
    // clearing write in the same cycle as an event leaves the flag set
    fork
      model.attempt(4'h4, 1'b1, 1);
      wr(4'h8, 16'h0001);
    join
    rd(4'h8, 16'h0003);
    chk({15'h0000, irq}, 16'h0001);
    // reset in mid-run clears counters, flags and mask
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    chk({15'h0000, irq}, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'h8, 16'h0000);
    rd(4'h9, 16'h0000);
    finish_test();
  end

endmodule : free_queue_starvation_counters_test

`default_nettype wire
